//--- windowed_watchdog_downcounter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_downcounter_tb;
  logic core_clk = 0, rst = 1, hw = 0, hopt = 0, halt = 0;
  wwd_pkg::wwd_bus_req_t bq = '0;
  logic [7:0] rd_data, v;
  logic wdg_reset_req, wdg_active;
  int err_total = 0, samples_checked = 0, reqs = 0;
  int cyc = 0, t_prev = 0, t_last = 0;
  logic [1:0] tsel = 2'd1;
  always #12.5 core_clk = ~core_clk;
  wwd_watchdog uut (.core_clk(core_clk), .rst(rst), .bus_req(bq), .rd_data(rd_data),
    .timebase_select(tsel), .hw_watchdog_option(hw), .halt_reset_option(hopt),
    .halt_exec(halt), .wdg_reset_req(wdg_reset_req), .wdg_active(wdg_active));
  // count reset request pulses
  always @(posedge core_clk)
  begin
    cyc++;
    if (wdg_reset_req === 1'b1)
    begin
      reqs++;
      t_prev = t_last;
      t_last = cyc;
    end
  end
  task chk(string n, logic [15:0] s, logic [15:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk) bq <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk) bq <= '0;
  endtask : wr
  task rd(logic [7:0] a);
    @(posedge core_clk) bq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk) bq <= '0;
    #1 v = rd_data;
  endtask : rd
  task do_reset;
    rst <= 1;
    repeat (6) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
  endtask : do_reset
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // main sequence
  initial
  begin
    do_reset;
    rd(8'h2a); chk("ctrl", v, 8'h7f);
    chk("active", {7'h0, wdg_active}, 8'h00);
    wr(8'h2b, 8'h00);
    rd(8'h2a); chk("ctrl", v, 8'h7f);
    rd(8'h2b); chk("unmapped", v, 8'h00);
    wr(8'h2a, 8'h40);
    repeat (16400) @(posedge core_clk);
    chk("reqs", 8'(reqs), 8'h00);
    rd(8'h2a); chk("count", v, 8'h3f);
    $display("inactive wrap done");
    wr(8'h2a, 8'hc5);
    rd(8'h2a); chk("ctrl", v, 8'hc5);
    wr(8'h2a, 8'h45);
    rd(8'h2a); chk("ctrl", v, 8'hc5);
    @(posedge core_clk) halt <= 1;
    @(posedge core_clk) halt <= 0;
    repeat (3) @(posedge core_clk);
    chk("reqs", 8'(reqs), 8'h00);
    hopt <= 1;
    @(posedge core_clk) halt <= 1;
    @(posedge core_clk) halt <= 0;
    repeat (3) @(posedge core_clk);
    chk("reqs", 8'(reqs), 8'h01);
    wr(8'h2a, 8'h80);
    repeat (3) @(posedge core_clk);
    chk("reqs", 8'(reqs), 8'h02);
    $display("halt and soft reset done");
    wr(8'h2a, 8'hc0);
    for (int i = 0; i < 16400 && reqs < 3; i++) @(posedge core_clk);
    chk("reqs", 8'(reqs), 8'h03);
    wr(8'h2a, 8'hc0);
    for (int i = 0; i < 16400 && reqs < 4; i++) @(posedge core_clk);
    chk("short step", 16'(t_last - t_prev), 16'((wwd_pkg::WWD_SHORT_BASE + 53) * wwd_pkg::WWD_SHORT_MULT));
    $display("active wrap done");
    do_reset;
    chk("active", {7'h0, wdg_active}, 8'h00);
    hw <= 1;
    repeat (3) @(posedge core_clk);
    chk("active", {7'h0, wdg_active}, 8'h01);
    $display("hardware option done");
    report_and_stop;
  end
  // hang guard
  initial
  begin
    repeat (60000) @(posedge core_clk);
    err_total++;
    report_and_stop;
  end
endmodule : windowed_watchdog_downcounter_tb
`default_nettype wire

//--- wwd_pkg.sv
// Behaviour
// RL1: seven-bit count lives in control register, decremented every 16384 divided-oscillator cycles.
// RL2: timeout selectable in 64 steps by the lower six count bits.
// RL3: when active, count wrapping 40h to 3Fh starts a reset cycle.
// RL4: counter keeps decrementing while inactive; wrap then causes no reset.
// RL5: software rewrites control register periodically with a value from FFh down to C0h.
// RL6: a control register write never restarts the prescaler.
// RL7: every reset returns activation to disabled.
// RL8: once set, activation ignores clearing writes; only reset clears it.
// RL9: a write setting activation with top count bit clear resets at once.
// RL10: when active and option selected, a halt instruction causes a reset.
// RL11: timebase selection picks phase constants 4/59, 8/53, 20/35, 49/54.
// RL12: below a quarter constant steps are 16384 cycles; above, correction steps apply.
// RL13: base period is 16384 cycles; short step is (constant plus 128) times 64; the code uses (constant plus 192) times 64.
// RL14: hardware watchdog option forces active; software activation bit has no effect.
// RL15: control register resets to 7Fh.
// RL16: reset request is a single-cycle pulse to the reset sequencer.
package wwd_pkg;

  // register map
  localparam logic [7:0] WWD_CTRL_OFFSET = 8'h2a;
  localparam logic [7:0] WWD_CTRL_RESET = 8'h7f;
  localparam int WWD_ACT_BIT = 7;
  localparam int WWD_TOP_BIT = 6;
  localparam logic [6:0] WWD_WRAP_FROM = 7'h40;

  // prescaler timing in divided-oscillator cycles
  localparam int WWD_STEP_CYCLES = 16384;
  localparam int WWD_SHORT_BASE = 192;
  localparam int WWD_SHORT_MULT = 64;

  // timebase phase constants: quarter-step divisor and short-step offset
  localparam logic [5:0] WWD_TB0_MSB = 6'h04;
  localparam logic [5:0] WWD_TB0_LSB = 6'h3b;
  localparam logic [5:0] WWD_TB1_MSB = 6'h08;
  localparam logic [5:0] WWD_TB1_LSB = 6'h35;
  localparam logic [5:0] WWD_TB2_MSB = 6'h14;
  localparam logic [5:0] WWD_TB2_LSB = 6'h23;
  localparam logic [5:0] WWD_TB3_MSB = 6'h31;
  localparam logic [5:0] WWD_TB3_LSB = 6'h36;

  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wwd_bus_req_t;

endpackage : wwd_pkg

//--- wwd_watchdog.sv
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module wwd_watchdog (
  input wire logic core_clk,
  input wire logic rst,
  input wire wwd_pkg::wwd_bus_req_t bus_req,
  output logic [7:0] rd_data,
  input wire logic [1:0] timebase_select,
  input wire logic hw_watchdog_option,
  input wire logic halt_reset_option,
  input wire logic halt_exec,
  output logic wdg_reset_req,
  output logic wdg_active
);

  localparam int STEP_W = 14;

  logic activation_bit_q;
  logic [6:0] delay_count_value_q;
  logic [STEP_W-1:0] step_cnt_q;
  logic [STEP_W-1:0] step_len_d;
  logic [6:0] quarter_acc_q;
  logic [6:0] quarter_acc_d;
  logic short_next_d;
  logic tick;
  logic active;
  logic ctrl_wr;
  logic ctrl_rd;
  logic wr_act;
  logic [5:0] tb_msb;
  logic [5:0] tb_lsb;

  assign ctrl_wr = bus_req.wr && (bus_req.addr == wwd_pkg::WWD_CTRL_OFFSET);
  assign ctrl_rd = bus_req.rd && (bus_req.addr == wwd_pkg::WWD_CTRL_OFFSET);
  // active if software enabled it or the hardware option forces it
  assign active = activation_bit_q | hw_watchdog_option; // RL14
  assign wr_act = activation_bit_q | bus_req.wdata[wwd_pkg::WWD_ACT_BIT] | hw_watchdog_option;
  assign tick = (step_cnt_q == '0);

  // phase constants per timebase selection
  always_comb
  begin
    case (timebase_select) // RL11
      2'd0:
      begin
        tb_msb = wwd_pkg::WWD_TB0_MSB;
        tb_lsb = wwd_pkg::WWD_TB0_LSB;
      end
      2'd1:
      begin
        tb_msb = wwd_pkg::WWD_TB1_MSB;
        tb_lsb = wwd_pkg::WWD_TB1_LSB;
      end
      2'd2:
      begin
        tb_msb = wwd_pkg::WWD_TB2_MSB;
        tb_lsb = wwd_pkg::WWD_TB2_LSB;
      end
      default:
      begin
        tb_msb = wwd_pkg::WWD_TB3_MSB;
        tb_lsb = wwd_pkg::WWD_TB3_LSB;
      end
    endcase
  end

  // quarter accumulator: a step is short each time 4*steps crosses a multiple of msb
  always_comb
  begin
    quarter_acc_d = quarter_acc_q + 7'd4; // RL12
    short_next_d = 1'b0;
    if (quarter_acc_d >= {1'b0, tb_msb})
    begin
      quarter_acc_d = quarter_acc_d - {1'b0, tb_msb};
      short_next_d = 1'b1;
    end
    if (short_next_d)
    begin
      // short step of (192 + lsb) * 64 cycles
      step_len_d = STEP_W'((wwd_pkg::WWD_SHORT_BASE + int'(tb_lsb)) * wwd_pkg::WWD_SHORT_MULT - 1);
    end
    else
    begin
      step_len_d = STEP_W'(wwd_pkg::WWD_STEP_CYCLES - 1); // RL13
    end
  end

  // free-running prescaler, never restarted by register writes
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      step_cnt_q <= STEP_W'(wwd_pkg::WWD_STEP_CYCLES - 1);
      quarter_acc_q <= '0;
    end
    else if (tick)
    begin
      step_cnt_q <= step_len_d; // RL6
      quarter_acc_q <= quarter_acc_d;
    end
    else
    begin
      step_cnt_q <= step_cnt_q - 1'b1; // RL1
    end
  end

  // activation bit: sticky until reset
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      activation_bit_q <= 1'b0; // RL7
    end
    else if (ctrl_wr && bus_req.wdata[wwd_pkg::WWD_ACT_BIT])
    begin
      activation_bit_q <= 1'b1; // RL8
    end
  end

  // count field: write wins over a same-cycle decrement
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      delay_count_value_q <= wwd_pkg::WWD_CTRL_RESET[6:0]; // RL15
    end
    else if (ctrl_wr)
    begin
      delay_count_value_q <= bus_req.wdata[6:0]; // RL2
    end
    else if (tick)
    begin
      delay_count_value_q <= delay_count_value_q - 7'd1; // RL4
    end
  end

  // reset request pulse
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wdg_reset_req <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      // a write overrides the wrap check, but never hides a halt
      wdg_reset_req <= (wr_act && !bus_req.wdata[wwd_pkg::WWD_TOP_BIT]) // RL9 RL16
        || (active && halt_reset_option && halt_exec); // RL10
    end
    else
    begin
      wdg_reset_req <= (active && tick && delay_count_value_q == wwd_pkg::WWD_WRAP_FROM) // RL3
        || (active && halt_reset_option && halt_exec); // RL10
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rd_data <= 8'h00;
    end
    else if (ctrl_rd)
    begin
      rd_data <= {activation_bit_q, delay_count_value_q};
    end
    else
    begin
      rd_data <= 8'h00;
    end
  end

  // activation state for the system
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wdg_active <= 1'b0;
    end
    else
    begin
      wdg_active <= active;
    end
  end

endmodule : wwd_watchdog
`default_nettype wire

//--- wwd_watchdog_checker.sv
`timescale 1ns/1ps
`default_nettype none
module wwd_watchdog_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire wwd_pkg::wwd_bus_req_t bus_req,
  input wire logic [7:0] rd_data,
  input wire logic [1:0] timebase_select,
  input wire logic hw_watchdog_option,
  input wire logic halt_reset_option,
  input wire logic halt_exec,
  input wire logic wdg_reset_req,
  input wire logic wdg_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // write strobe aimed at the control register
  logic cw;
  assign cw = bus_req.wr && bus_req.addr == 8'h2a;
  chk_req_one_cycle: assert property (wdg_reset_req |=> !wdg_reset_req)
    else $error("reset request longer than one cycle");
  chk_rd_data_idle: assert property (!(bus_req.rd && bus_req.addr == 8'h2a)
    |=> rd_data == 8'h00)
    else $error("read data not zero");
  chk_soft_reset: assert property (cw && bus_req.wdata[7:6] == 2'b10 |=> wdg_reset_req)
    else $error("software reset missing");
  chk_halt_reset: assert property (halt_exec && halt_reset_option && wdg_active
    |=> wdg_reset_req)
    else $error("halt reset missing");
  chk_active_sticky: assert property (wdg_active |=> wdg_active)
    else $error("watchdog left active state");
  chk_active_set: assert property (cw && bus_req.wdata[7] |-> ##[1:2] wdg_active)
    else $error("activation not taken");
  chk_hw_forces: assert property (hw_watchdog_option [*2] |=> wdg_active)
    else $error("hardware option not active");
  chk_idle_quiet: assert property ((!wdg_active && !hw_watchdog_option && !bus_req.wr) [*4]
    |=> !wdg_reset_req)
    else $error("reset request while inactive");
endmodule : wwd_watchdog_checker
bind wwd_watchdog wwd_watchdog_checker chk (.core_clk(core_clk), .rst(rst),
  .bus_req(bus_req), .rd_data(rd_data), .timebase_select(timebase_select),
  .hw_watchdog_option(hw_watchdog_option), .halt_reset_option(halt_reset_option),
  .halt_exec(halt_exec), .wdg_reset_req(wdg_reset_req), .wdg_active(wdg_active));
`default_nettype wire
